// file: hdl/ccsc_pkg.sv
/*
 * Package for the CPU clock source control block: register offsets, field
 * positions, reset values and the carrier types shared by the design.
 * Assumes an 8-bit register port with a 2-bit register address.
 */
package ccsc_pkg;

    localparam int ADDR_W = 2;
    localparam int DATA_W = 8;

    ////////////////////////////////////////////////////////////////////////////
    // Register offsets.
    localparam logic [1:0] OFF_PROC_CLK_CTRL = 2'h0;
    localparam logic [1:0] OFF_INT_OSC_MODE = 2'h1;
    localparam logic [1:0] OFF_MAIN_CLK_MODE = 2'h2;
    localparam logic [1:0] OFF_PERIPH_STATUS = 2'h3;

    ////////////////////////////////////////////////////////////////////////////
    // Field positions.
    localparam int PCC_DIV_LSB = 0;
    localparam int PCC_DIV_MSB = 2;
    localparam int PCC_SUBSEL_BIT = 4;
    localparam int PCC_SUBFLAG_BIT = 5;
    localparam int IOM_IHS_HALT_BIT = 0;
    localparam int IOM_HS_HALT_BIT = 1;
    localparam int MCM_MODE0_BIT = 0;
    localparam int MCM_STATUS_BIT = 1;
    localparam int MCM_SRCPICK_BIT = 2;
    localparam int PST_STOPPED_BIT = 0;
    localparam int PST_RUNNING_BIT = 1;

    ////////////////////////////////////////////////////////////////////////////
    // Values after reset and counts.
    localparam logic [2:0] DIV_RST = 3'h0;
    localparam logic [2:0] DIV_MAX = 3'h4;
    localparam logic SUBSEL_RST = 1'b0;
    localparam logic IHS_HALT_RST = 1'b0;
    localparam logic HS_HALT_RST = 1'b1;
    localparam logic MODE0_RST = 1'b0;
    localparam logic SRCPICK_RST = 1'b0;
    localparam int RL_DIV_W = 7;
    localparam logic [RL_DIV_W-1:0] RL_DIV_LAST = 7'h7F;
    localparam logic [3:0] CNT_RST = 4'h0;
    localparam logic STOPPED_RST = 1'b0;
    localparam logic LOCKED_RST = 1'b0;

    ////////////////////////////////////////////////////////////////////////////
    // Synchroniser lanes for the source waveforms arriving on pins.
    localparam int SRC_N = 8;
    localparam int SRC_HS_XTAL = 0;
    localparam int SRC_HS_EXT = 1;
    localparam int SRC_IHS = 2;
    localparam int SRC_SUB = 3;
    localparam int SRC_RL = 4;
    localparam int SRC_PER_EXT = 5;
    localparam int SRC_TM0_0 = 6;
    localparam int SRC_TM0_1 = 7;

    // CPU clock selection as applied to the multiplexer.
    typedef struct packed {
        logic       subsel;
        logic       mode0;
        logic [2:0] div;
    } ccsc_cfg_t;

    localparam ccsc_cfg_t CFG_RST = '{subsel: SUBSEL_RST, mode0: MODE0_RST, div: DIV_RST};

endpackage

// file: hdl/ccsc_top.sv
/*
 * CPU clock source control: register file, CPU clock selection with
 * boundary-aligned switching, peripheral clock enables and the clock enables
 * of the blocks that keep their own clock.
 * Assumes source oscillators arrive as asynchronous square waves on pins and
 * are far slower than i_core_clk; every generated clock is a one-cycle enable.
 */
//
// Notes on behaviour
// - The high-speed source pick takes only the first write after reset.
// - Peripherals get no clock while it is stopped; software then reinitialises them.
// - Watchdog runs from the low-speed clock whatever the main selections are.
// - Timer unit B on divided low-speed clock ignores peripheral clock selection.
// - External-clocked peripherals run independently, except 16-bit timers 0 and 1.
// - A CPU clock change takes effect one CPU clock after the write.
`timescale 1ns/1ps

module ccsc_top
    import ccsc_pkg::*;
(
    input  wire logic              i_core_clk,           // Core clock, 100 MHz.
    input  wire logic              i_rst,                // Asynchronous reset, active high.
    input  wire logic [ADDR_W-1:0] i_addr,               // Register address.
    input  wire logic [DATA_W-1:0] i_wdata,              // Write data.
    input  wire logic              i_wr,                 // Write strobe.
    input  wire logic              i_rd,                 // Read strobe.
    output logic [DATA_W-1:0]      o_rdata,              // Read data, cycle after i_rd.
    input  wire logic              i_hs_xtal,            // High-speed crystal waveform.
    input  wire logic              i_hs_ext,             // High-speed external clock pin.
    input  wire logic              i_ihs_osc,            // Internal high-speed oscillator.
    input  wire logic              i_sub_osc,            // Subsystem clock waveform.
    input  wire logic              i_rl_osc,             // Low-speed internal clock.
    input  wire logic              i_per_ext_clk,        // Peripheral external clock pin.
    input  wire logic [1:0]        i_timer_ext_count_pin, // Count pins of 16-bit timers 0 and 1.
    input  wire logic              i_tmrb_sel_rl,        // Timer unit B counts divided low-speed clock.
    output logic                   o_cpu_clk_en,         // CPU clock enable pulse.
    output logic                   o_periph_clk_en,      // Peripheral clock enable pulse.
    output logic                   o_periph_run,         // Peripheral clock is running.
    output logic                   o_wdt_clk_en,         // Watchdog clock enable pulse.
    output logic                   o_tmrb_clk_en,        // Timer unit B clock enable pulse.
    output logic                   o_per_ext_clk_en,     // External-clock peripheral enable pulse.
    output logic [1:0]             o_tm0_cnt_en,         // 16-bit timer count edge pulses.
    output logic                   o_main_clock_status_flag, // CPU on high-speed system clock.
    output logic                   o_cpu_on_subclock_flag   // CPU on subsystem clock.
);

    ////////////////////////////////////////////////////////////////////////////
    // Two flip-flops per pin, then a third stage used only for edge detection.
    logic [SRC_N-1:0] pin_in;
    logic [SRC_N-1:0] sync1_r;
    logic [SRC_N-1:0] sync2_r;
    logic [SRC_N-1:0] sync3_r;
    logic [SRC_N-1:0] edge_t;

    assign pin_in = {i_timer_ext_count_pin[1], i_timer_ext_count_pin[0], i_per_ext_clk, i_rl_osc,
                     i_sub_osc, i_ihs_osc, i_hs_ext, i_hs_xtal};

    for (genvar g = 0; g < SRC_N; g++) begin : g_sync
        always_ff @(posedge i_core_clk or posedge i_rst) begin
            if (i_rst) begin
                sync1_r[g] <= 1'b0;
                sync2_r[g] <= 1'b0;
                sync3_r[g] <= 1'b0;
            end else begin
                sync1_r[g] <= pin_in[g];
                sync2_r[g] <= sync1_r[g];
                sync3_r[g] <= sync2_r[g];
            end
        end
        assign edge_t[g] = sync2_r[g] & ~sync3_r[g];
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register file.
    logic [2:0] div_r, div_nxt;
    logic subsel_r, subsel_nxt;
    logic ihs_halt_r, ihs_halt_nxt;
    logic hs_halt_r, hs_halt_nxt;
    logic mode0_r, mode0_nxt;
    logic srcpick_r, srcpick_nxt;
    logic pick_locked_r, pick_locked_nxt;
    logic stopped_r, stopped_nxt;
    logic [DATA_W-1:0] rdata_nxt;

    // Applied CPU selection, owned by the clock group below.
    ccsc_cfg_t app_r;
    logic per_run;

    function automatic logic [DATA_W-1:0] read_mux(input logic [ADDR_W-1:0] a);
        logic [DATA_W-1:0] v;
        v = '0;
        unique case (a)
            OFF_PROC_CLK_CTRL: begin
                v[PCC_DIV_MSB:PCC_DIV_LSB] = div_r;
                v[PCC_SUBSEL_BIT] = subsel_r;
                v[PCC_SUBFLAG_BIT] = app_r.subsel;
            end
            OFF_INT_OSC_MODE: begin
                v[IOM_IHS_HALT_BIT] = ihs_halt_r;
                v[IOM_HS_HALT_BIT] = hs_halt_r;
            end
            OFF_MAIN_CLK_MODE: begin
                v[MCM_MODE0_BIT] = mode0_r;
                v[MCM_STATUS_BIT] = app_r.mode0 & ~app_r.subsel;
                v[MCM_SRCPICK_BIT] = srcpick_r;
            end
            OFF_PERIPH_STATUS: begin
                v[PST_STOPPED_BIT] = stopped_r;
                v[PST_RUNNING_BIT] = per_run;
            end
        endcase
        return v;
    endfunction

    always_comb begin
        div_nxt = div_r;
        subsel_nxt = subsel_r;
        ihs_halt_nxt = ihs_halt_r;
        hs_halt_nxt = hs_halt_r;
        mode0_nxt = mode0_r;
        srcpick_nxt = srcpick_r;
        pick_locked_nxt = pick_locked_r;
        stopped_nxt = stopped_r;
        if (i_wr) begin
            unique case (i_addr)
                OFF_PROC_CLK_CTRL: begin
                    // Bits 3, 6 and 7 are not stored and read back as zero.
                    div_nxt = i_wdata[PCC_DIV_MSB:PCC_DIV_LSB];
                    subsel_nxt = i_wdata[PCC_SUBSEL_BIT];
                end
                OFF_INT_OSC_MODE: begin
                    ihs_halt_nxt = i_wdata[IOM_IHS_HALT_BIT];
                    hs_halt_nxt = i_wdata[IOM_HS_HALT_BIT];
                end
                OFF_MAIN_CLK_MODE: begin
                    mode0_nxt = i_wdata[MCM_MODE0_BIT];
                    if (!pick_locked_r) begin
                        srcpick_nxt = i_wdata[MCM_SRCPICK_BIT];
                    end
                    pick_locked_nxt = 1'b1;
                end
                OFF_PERIPH_STATUS: begin
                    if (i_wdata[PST_STOPPED_BIT]) begin
                        stopped_nxt = 1'b0;
                    end
                end
            endcase
        end
        // A stop seen in the clearing cycle still sets the flag.
        if (!per_run) begin
            stopped_nxt = 1'b1;
        end
        rdata_nxt = i_rd ? read_mux(i_addr) : '0;
    end

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            div_r <= DIV_RST;
            subsel_r <= SUBSEL_RST;
            ihs_halt_r <= IHS_HALT_RST;
            hs_halt_r <= HS_HALT_RST;
            mode0_r <= MODE0_RST;
            srcpick_r <= SRCPICK_RST;
            pick_locked_r <= LOCKED_RST;
            stopped_r <= STOPPED_RST;
            o_rdata <= '0;
        end else begin
            div_r <= div_nxt;
            subsel_r <= subsel_nxt;
            ihs_halt_r <= ihs_halt_nxt;
            hs_halt_r <= hs_halt_nxt;
            mode0_r <= mode0_nxt;
            srcpick_r <= srcpick_nxt;
            pick_locked_r <= pick_locked_nxt;
            stopped_r <= stopped_nxt;
            o_rdata <= rdata_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Clock generation. Sources are gated by their halt bits.
    logic hs_t, ihs_t, sub_t, rl_t, rl128_t, per_t, cpu_src_t, cpu_t;
    logic [3:0] cnt_r, cnt_nxt;
    logic [RL_DIV_W-1:0] rl_cnt_r, rl_cnt_nxt;
    ccsc_cfg_t app_nxt, pend;

    // Longest division for codes above the documented range.
    function automatic logic [3:0] div_limit(input ccsc_cfg_t c);
        logic [2:0] d;
        d = (c.div > DIV_MAX) ? DIV_MAX : c.div;
        return c.subsel ? CNT_RST : 4'((5'h01 << d) - 5'h01);
    endfunction

    assign hs_t = (srcpick_r ? edge_t[SRC_HS_EXT] : edge_t[SRC_HS_XTAL]) & ~hs_halt_r;
    assign ihs_t = edge_t[SRC_IHS] & ~ihs_halt_r;
    assign sub_t = edge_t[SRC_SUB];
    assign rl_t = edge_t[SRC_RL];
    assign rl128_t = rl_t && (rl_cnt_r == RL_DIV_LAST);
    assign per_run = app_r.mode0 ? ~hs_halt_r : ~ihs_halt_r;
    assign per_t = app_r.mode0 ? hs_t : ihs_t;
    assign pend = '{subsel: subsel_r, mode0: mode0_r, div: div_r};

    always_comb begin
        cpu_src_t = app_r.subsel ? sub_t : per_t;
        cpu_t = cpu_src_t && (cnt_r >= div_limit(app_r));
        cnt_nxt = cnt_r;
        app_nxt = app_r;
        if (cpu_t) begin
            // New selection only at a period end, so no shortened pulse.
            cnt_nxt = CNT_RST;
            app_nxt = pend;
        end else if (cpu_src_t) begin
            cnt_nxt = 4'(cnt_r + 4'h1);
        end
        rl_cnt_nxt = rl_t ? RL_DIV_W'(rl_cnt_r + 1'b1) : rl_cnt_r;
    end

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            cnt_r <= CNT_RST;
            app_r <= CFG_RST;
            rl_cnt_r <= '0;
            o_cpu_clk_en <= 1'b0;
            o_periph_clk_en <= 1'b0;
            o_periph_run <= 1'b0;
            o_wdt_clk_en <= 1'b0;
            o_tmrb_clk_en <= 1'b0;
            o_per_ext_clk_en <= 1'b0;
            o_tm0_cnt_en <= 2'h0;
            o_main_clock_status_flag <= 1'b0;
            o_cpu_on_subclock_flag <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            app_r <= app_nxt;
            rl_cnt_r <= rl_cnt_nxt;
            o_cpu_clk_en <= cpu_t;
            o_periph_clk_en <= per_t && per_run;
            o_periph_run <= per_run;
            o_wdt_clk_en <= rl_t;
            o_tmrb_clk_en <= i_tmrb_sel_rl ? rl128_t : per_t;
            o_per_ext_clk_en <= edge_t[SRC_PER_EXT];
            o_tm0_cnt_en <= {edge_t[SRC_TM0_1], edge_t[SRC_TM0_0]} & {2{per_run}};
            o_main_clock_status_flag <= app_nxt.mode0 & ~app_nxt.subsel;
            o_cpu_on_subclock_flag <= app_nxt.subsel;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Assertions.
    sequence s_pick_write;
        i_wr && i_addr == OFF_MAIN_CLK_MODE && pick_locked_r;
    endsequence

    pick_once_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
        s_pick_write |=> srcpick_r == $past(srcpick_r)) else $error("source pick changed after lock");

    periph_gate_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
        !per_run |=> !o_periph_clk_en && !o_periph_run && stopped_r) else $error("peripheral clock ran while stopped");

    wdt_clock_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
        o_wdt_clk_en == $past(edge_t[SRC_RL])) else $error("watchdog clock not from low-speed source");

    timer_b_rl_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
        i_tmrb_sel_rl && rl_t && rl_cnt_r == RL_DIV_LAST |=> o_tmrb_clk_en ##1 !o_tmrb_clk_en)
        else $error("timer unit B missed divided low-speed tick");

    ext_clock_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
        edge_t[SRC_PER_EXT] && !per_run |=> o_per_ext_clk_en && o_tm0_cnt_en == 2'h0)
        else $error("external clock wrongly tied to peripheral clock");

    sequence s_change_req;
        cpu_t && pend != app_r;
    endsequence

    cpu_switch_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
        s_change_req |=> app_r == $past(pend) && o_cpu_clk_en ##1 !o_cpu_clk_en)
        else $error("CPU clock change not applied after one clock");

    no_glitch_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
        app_r != $past(app_r) |-> $past(cpu_t) && cnt_r == CNT_RST) else $error("CPU clock switched mid period");

    sequence s_main_write;
        i_wr && i_addr == OFF_MAIN_CLK_MODE;
    endsequence

    pick_lock_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
        s_main_write |=> pick_locked_r && srcpick_r == ($past(pick_locked_r) ? $past(srcpick_r)
        : $past(i_wdata[MCM_SRCPICK_BIT]))) else $error("source pick write not taken once");

    src_halt_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
        !app_r.subsel && !per_run |-> !cpu_t) else $error("CPU clock ran from a halted source");

    tmrb_per_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
        !i_tmrb_sel_rl |=> o_tmrb_clk_en == $past(per_t)) else $error("timer unit B lost peripheral clock");

    div_count_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
        cpu_src_t && !cpu_t |=> !o_cpu_clk_en && cnt_r == 4'($past(cnt_r) + 4'h1))
        else $error("CPU divider skipped a source edge");

endmodule

// file: sim/ccsc_top_tb.sv
/*
 * Self-checking testbench for ccsc_top: register reads and writes, CPU clock
 * spacing per divider code, write-once source pick and the clocks that must
 * keep running while the peripheral clock is stopped.
 * Assumes the source waveforms are far slower than the core clock.
 */
`timescale 1ns/1ps

module ccsc_top_tb;
    import ccsc_pkg::*;

    logic i_core_clk, i_rst, i_wr, i_rd, i_tmrb_sel_rl;
    logic [ADDR_W-1:0] i_addr;
    logic [DATA_W-1:0] i_wdata, o_rdata;
    logic i_hs_xtal, i_hs_ext, i_ihs_osc, i_sub_osc, i_rl_osc, i_per_ext_clk;
    logic [1:0] i_timer_ext_count_pin, o_tm0_cnt_en;
    logic o_cpu_clk_en, o_periph_clk_en, o_periph_run, o_wdt_clk_en, o_tmrb_clk_en;
    logic o_per_ext_clk_en, o_main_clock_status_flag, o_cpu_on_subclock_flag;
    int error_cnt = 0, compares = 0, cyc = 0;
    int n_cpu = 0, n_per = 0, n_wdt = 0, n_tmb = 0, n_ext = 0, n_tm0 = 0;
    int s_cpu, s_per, s_wdt, s_tmb, s_ext, s_tm0, g;
    int dcode [4] = '{0, 1, 2, 7};
    int dgap [4] = '{8, 16, 32, 128};

    ccsc_top dut_u (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
        .i_rd(i_rd), .o_rdata(o_rdata), .i_hs_xtal(i_hs_xtal), .i_hs_ext(i_hs_ext), .i_ihs_osc(i_ihs_osc),
        .i_sub_osc(i_sub_osc), .i_rl_osc(i_rl_osc), .i_per_ext_clk(i_per_ext_clk),
        .i_timer_ext_count_pin(i_timer_ext_count_pin), .i_tmrb_sel_rl(i_tmrb_sel_rl), .o_cpu_clk_en(o_cpu_clk_en),
        .o_periph_clk_en(o_periph_clk_en), .o_periph_run(o_periph_run), .o_wdt_clk_en(o_wdt_clk_en),
        .o_tmrb_clk_en(o_tmrb_clk_en), .o_per_ext_clk_en(o_per_ext_clk_en), .o_tm0_cnt_en(o_tm0_cnt_en),
        .o_main_clock_status_flag(o_main_clock_status_flag), .o_cpu_on_subclock_flag(o_cpu_on_subclock_flag));

    initial begin
        i_core_clk = 1'b0;
        forever #5 i_core_clk = ~i_core_clk;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Source waveforms, each a fixed number of core cycles per period.
    always @(posedge i_core_clk) begin
        cyc <= cyc + 1;
        i_ihs_osc <= (cyc % 8) < 4;
        i_hs_xtal <= (cyc % 10) < 5;
        i_hs_ext <= (cyc % 10) < 5;
        i_sub_osc <= (cyc % 14) < 7;
        i_rl_osc <= (cyc % 6) < 3;
        i_per_ext_clk <= (cyc % 12) < 6;
        i_timer_ext_count_pin <= {(cyc % 16) < 8, (cyc % 18) < 9};
        n_cpu <= n_cpu + int'(o_cpu_clk_en);
        n_per <= n_per + int'(o_periph_clk_en);
        n_wdt <= n_wdt + int'(o_wdt_clk_en);
        n_tmb <= n_tmb + int'(o_tmrb_clk_en);
        n_ext <= n_ext + int'(o_per_ext_clk_en);
        n_tm0 <= n_tm0 + int'(o_tm0_cnt_en[0]) + int'(o_tm0_cnt_en[1]);
    end

    task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chk_rng(input string what, input int lo, input int hi, input int got);
        compares++;
        if (got < lo || got > hi) begin
            error_cnt++;
            $display("[ERR] %s expected %0d..%0d seen %0d", what, lo, hi, got);
        end
    endtask

    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge i_core_clk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_core_clk);
        i_wr <= 1'b0;
    endtask

    task automatic rd(input string what, input logic [1:0] a, input logic [7:0] exp);
        @(posedge i_core_clk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_core_clk);
        i_rd <= 1'b0;
        #1;
        chk8(what, exp, o_rdata);
    endtask

    // Gap between the second and third CPU pulse, so a pending switch has landed.
    task automatic cpu_gap(output int n);
        int k;
        n = 0;
        for (k = 0; k < 3; k++) begin
            n = 0;
            do begin
                @(posedge i_core_clk);
                n++;
            end while (o_cpu_clk_en !== 1'b1 && n < 400);
        end
    endtask

    task automatic snap();
        s_cpu = n_cpu; s_per = n_per; s_wdt = n_wdt; s_tmb = n_tmb; s_ext = n_ext; s_tm0 = n_tm0;
        repeat (1600) @(posedge i_core_clk);
    endtask

    task automatic print_verdict();
        $display("compares %0d error_cnt %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    initial begin
        repeat (60000) @(posedge i_core_clk);
        error_cnt++;
        print_verdict();
    end

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        i_rst = 1'b1; i_wr = 1'b0; i_rd = 1'b0; i_addr = 2'h0; i_wdata = 8'h00; i_tmrb_sel_rl = 1'b1;
        i_ihs_osc = 1'b0; i_hs_xtal = 1'b0; i_hs_ext = 1'b0; i_sub_osc = 1'b0; i_rl_osc = 1'b0;
        i_per_ext_clk = 1'b0; i_timer_ext_count_pin = 2'h0;
        repeat (3) @(posedge i_core_clk);
        i_rst <= 1'b0;
        rd("pcc_rst", OFF_PROC_CLK_CTRL, 8'h00);
        rd("osc_rst", OFF_INT_OSC_MODE, 8'h02);
        rd("mcm_rst", OFF_MAIN_CLK_MODE, 8'h00);
        rd("pst_rst", OFF_PERIPH_STATUS, 8'h02);
        // Software keeps bits 3, 6 and 7 of the processor clock register at zero.
        wr(OFF_PROC_CLK_CTRL, 8'h02);
        rd("pcc_loose", OFF_PROC_CLK_CTRL, 8'h02);
        for (int i = 0; i < 4; i++) begin
            wr(OFF_PROC_CLK_CTRL, 8'(dcode[i]));
            cpu_gap(g);
            chk_rng("cpu_gap", dgap[i], dgap[i], g);
        end
        wr(OFF_PROC_CLK_CTRL, 8'h00);
        wr(OFF_MAIN_CLK_MODE, 8'h04);
        wr(OFF_MAIN_CLK_MODE, 8'h00);
        rd("pick_once", OFF_MAIN_CLK_MODE, 8'h04);
        // Move the CPU to the subclock before halting the fast oscillator.
        wr(OFF_PROC_CLK_CTRL, 8'h10);
        cpu_gap(g);
        cpu_gap(g);
        chk_rng("sub_gap", 14, 14, g);
        chk8("sub_flag", 8'h01, {7'h0, o_cpu_on_subclock_flag});
        chk8("main_flag", 8'h00, {7'h0, o_main_clock_status_flag});
        rd("pcc_sub", OFF_PROC_CLK_CTRL, 8'h30);
        wr(OFF_INT_OSC_MODE, 8'h03);
        repeat (20) @(posedge i_core_clk);
        snap();
        chk8("run_off", 8'h00, {7'h0, o_periph_run});
        chk_rng("per_off", 0, 0, n_per - s_per);
        chk_rng("tm0_off", 0, 0, n_tm0 - s_tm0);
        chk_rng("wdt_on", 265, 268, n_wdt - s_wdt);
        chk_rng("tmrb_rl", 2, 3, n_tmb - s_tmb);
        chk_rng("ext_on", 132, 134, n_ext - s_ext);
        chk_rng("cpu_sub", 113, 115, n_cpu - s_cpu);
        wr(OFF_PERIPH_STATUS, 8'h01);
        rd("stop_sticky", OFF_PERIPH_STATUS, 8'h01);
        wr(OFF_INT_OSC_MODE, 8'h02);
        i_tmrb_sel_rl <= 1'b0;
        repeat (30) @(posedge i_core_clk);
        wr(OFF_PERIPH_STATUS, 8'h01);
        rd("stop_clear", OFF_PERIPH_STATUS, 8'h02);
        snap();
        chk8("run_on", 8'h01, {7'h0, o_periph_run});
        chk_rng("per_on", 199, 201, n_per - s_per);
        chk_rng("tm0_on", 187, 191, n_tm0 - s_tm0);
        chk_rng("tmrb_per", 199, 201, n_tmb - s_tmb);
        chk_rng("wdt_on2", 265, 268, n_wdt - s_wdt);
        // Hand the CPU to the high-speed system clock, then halt the internal one.
        wr(OFF_INT_OSC_MODE, 8'h00);
        wr(OFF_MAIN_CLK_MODE, 8'h01);
        wr(OFF_PROC_CLK_CTRL, 8'h00);
        cpu_gap(g);
        cpu_gap(g);
        chk_rng("hs_gap", 10, 10, g);
        chk8("main_on", 8'h01, {7'h0, o_main_clock_status_flag});
        wr(OFF_INT_OSC_MODE, 8'h01);
        rd("mcm_hs", OFF_MAIN_CLK_MODE, 8'h07);
        rd("pst_hs", OFF_PERIPH_STATUS, 8'h02);
        snap();
        chk_rng("cpu_hs", 159, 161, n_cpu - s_cpu);
        chk_rng("per_hs", 159, 161, n_per - s_per);
        chk_rng("tmrb_hs", 159, 161, n_tmb - s_tmb);
        print_verdict();
    end

endmodule
